// >>> hw/tac_alarm_bank.sv
// thermal alarm configuration bank with apb register access
`timescale 1ns/100ps
`default_nettype none
module tac_alarm_bank #(
	parameter int TW = 16,
	parameter int AW = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [TW-1:0] local_temp,
	input wire logic [TW-1:0] remote_temp,
	input wire logic first_fan_alarm_event,
	input wire logic second_fan_alarm_event,
	input wire logic fan_failure_detected,
	input wire logic [7:0] normal_duty_code,
	output logic [7:0] pwm_duty_code,
	output logic [5:0] ideality_code,
	output logic alert_out,
	output logic shutdown_output_pin,
	output logic fan_fail_output_pin,
	output logic irq
);

	////////////////////////////////////////////////////////////////////////
	// storage

	logic [7:0] cfg_r [tac_pkg::IDX_FIRST:tac_pkg::IDX_LAST];
	logic [5:0] irq_stat_r;
	logic [5:0] irq_mask_r;
	tac_pkg::tac_out_t out_r;
	tac_pkg::tac_out_t out_nxt;
	tac_pkg::tac_alarm_t alm;
	wire logic [7:0] mask_w;
	wire logic [5:0] alm_vec;

	////////////////////////////////////////////////////////////////////////
	// apb decode

	wire logic [5:0] idx;
	wire logic addr_ok;
	wire logic in_cfg;
	wire logic mapped;
	wire logic setup;
	wire logic wr_go;
	wire logic [7:0] wbyte;
	logic [31:0] rd_nxt;

	// word index; low address bits and high bits must be zero
	assign idx = paddr[7:2];
	// a shift keeps the range legal when no bits stand above the index
	assign addr_ok = (paddr[1:0] == 2'b00) && ((paddr >> 8) == '0);
	assign in_cfg = (idx >= tac_pkg::IDX_FIRST) && (idx <= tac_pkg::IDX_LAST);
	assign mapped = addr_ok && (in_cfg || idx == tac_pkg::IDX_IRQ_STAT
		|| idx == tac_pkg::IDX_IRQ_MASK || idx == tac_pkg::IDX_LIVE);
	assign setup = psel && !penable;
	// a write lands only on the completing access edge
	assign wr_go = psel && penable && pready && pwrite && mapped;
	assign wbyte = pwdata[7:0];

	// read mux; data is taken in setup so every read costs one wait-free access
	always_comb begin
		rd_nxt = 32'h0000_0000;
		if (in_cfg) begin
			rd_nxt[7:0] = cfg_r[idx];
		end else if (idx == tac_pkg::IDX_IRQ_STAT) begin
			rd_nxt[5:0] = irq_stat_r;
		end else if (idx == tac_pkg::IDX_IRQ_MASK) begin
			rd_nxt[5:0] = irq_mask_r;
		end else if (idx == tac_pkg::IDX_LIVE) begin
			rd_nxt[5:0] = alm_vec;
			rd_nxt[8] = out_r.ffail;
			rd_nxt[9] = out_r.shut;
			rd_nxt[10] = out_r.alert;
		end
		if (!mapped) begin
			rd_nxt = 32'h0000_0000;
		end
	end

	// answer registers; pready rises for exactly the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else begin
			pready <= setup;
			if (setup) begin
				pslverr <= !mapped;
				prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// configuration words

	// power-up loads the stored image; writes force reserved bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = tac_pkg::IDX_FIRST; i <= tac_pkg::IDX_LAST; i++) begin
				cfg_r[i] <= tac_pkg::tac_rst_val(6'(i));
			end
		end else if (wr_go && in_cfg) begin
			cfg_r[idx] <= tac_pkg::tac_wr_val(idx, wbyte);
		end
	end

	assign mask_w = cfg_r[tac_pkg::IDX_MASK];

	////////////////////////////////////////////////////////////////////////
	// limit comparators

	wire logic [TW-1:0] lim_lh;
	wire logic [TW-1:0] lim_lot;
	wire logic [TW-1:0] lim_rh;
	wire logic [TW-1:0] lim_rot;

	// upper byte sign and integer, lower byte fraction
	assign lim_lh = {cfg_r[tac_pkg::IDX_LHU], cfg_r[tac_pkg::IDX_LHL]};
	assign lim_lot = {cfg_r[tac_pkg::IDX_LOTU], cfg_r[tac_pkg::IDX_LOTL]};
	assign lim_rh = {cfg_r[tac_pkg::IDX_RHU], cfg_r[tac_pkg::IDX_RHL]};
	assign lim_rot = {cfg_r[tac_pkg::IDX_ROTU], cfg_r[tac_pkg::IDX_ROTL]};

	// one signed comparator per set-point
	tac_limit_cmp #(.W(TW)) u_cmp_lh (
		.pclk(pclk),
		.presetn(presetn),
		.temp(local_temp),
		.limit(lim_lh),
		.exceed_r(alm.lh)
	);

	tac_limit_cmp #(.W(TW)) u_cmp_lot (
		.pclk(pclk),
		.presetn(presetn),
		.temp(local_temp),
		.limit(lim_lot),
		.exceed_r(alm.lot)
	);

	tac_limit_cmp #(.W(TW)) u_cmp_rh (
		.pclk(pclk),
		.presetn(presetn),
		.temp(remote_temp),
		.limit(lim_rh),
		.exceed_r(alm.rh)
	);

	tac_limit_cmp #(.W(TW)) u_cmp_rot (
		.pclk(pclk),
		.presetn(presetn),
		.temp(remote_temp),
		.limit(lim_rot),
		.exceed_r(alm.rot)
	);

	// fan alarms come from the tach logic on this clock
	assign alm.t2 = second_fan_alarm_event;
	assign alm.t1 = first_fan_alarm_event;
	assign alm_vec = alm;

	////////////////////////////////////////////////////////////////////////
	// alarm outputs

	// a mask bit at one blocks its source from the output
	always_comb begin
		out_nxt.alert = (alm.lh && !mask_w[tac_pkg::MB_LH])
			|| (alm.rh && !mask_w[tac_pkg::MB_RH]);
		out_nxt.shut = (alm.lot && !mask_w[tac_pkg::MB_LOT])
			|| (alm.rot && !mask_w[tac_pkg::MB_ROT]);
		out_nxt.ffail = (alm.t2 && !mask_w[tac_pkg::MB_T2])
			|| (alm.t1 && !mask_w[tac_pkg::MB_T1]);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_r <= '0;
		end else begin
			out_r <= out_nxt;
		end
	end

	assign alert_out = out_r.alert;
	assign shutdown_output_pin = out_r.shut;
	assign fan_fail_output_pin = out_r.ffail;

	////////////////////////////////////////////////////////////////////////
	// pwm duty and ideality

	// failure duty replaces the normal code, same encoding
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pwm_duty_code <= tac_pkg::RST_FDUTY;
			ideality_code <= tac_pkg::RST_IDEAL[5:0];
		end else begin
			pwm_duty_code <= fan_failure_detected ? cfg_r[tac_pkg::IDX_FDUTY]
				: normal_duty_code;
			ideality_code <= cfg_r[tac_pkg::IDX_IDEAL][5:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupts

	wire logic [5:0] w1c;
	wire logic [5:0] stat_nxt;

	// set wins over a write-one clear in the same cycle
	assign w1c = (wr_go && idx == tac_pkg::IDX_IRQ_STAT) ? wbyte[5:0] : 6'h00;
	assign stat_nxt = (irq_stat_r & ~w1c) | alm_vec;

	// irq level only reflects unmasked sticky bits; mask is per source
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_r <= 6'h00;
			irq_mask_r <= tac_pkg::RST_IRQ_MASK;
			irq <= 1'b0;
		end else begin
			irq_stat_r <= stat_nxt;
			if (wr_go && idx == tac_pkg::IDX_IRQ_MASK) begin
				irq_mask_r <= wbyte[5:0];
			end
			irq <= |(stat_nxt & irq_mask_r);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// checks

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_wr_fduty;
		psel && penable && pready && pwrite && addr_ok && idx == tac_pkg::IDX_FDUTY;
	endsequence

	sequence s_wr_ideal;
		psel && penable && pready && pwrite && addr_ok && idx == tac_pkg::IDX_IDEAL;
	endsequence

	sequence s_fail_after_wr;
		s_wr_fduty ##2 fan_failure_detected;
	endsequence

	a_fail_duty_path: assert property (
		s_fail_after_wr |=> pwm_duty_code == $past(pwdata[7:0], 3))
		else $error("failure duty not applied");

	a_local_high_alert: assert property (
		alm.lh && !mask_w[tac_pkg::MB_LH] |=> alert_out)
		else $error("local high alarm did not raise alert");

	a_local_ot_shutdown_output_pin: assert property (
		alm.lot && !mask_w[tac_pkg::MB_LOT] |=> shutdown_output_pin)
		else $error("local overtemperature did not raise shutdown");

	a_remote_high_alert: assert property (
		alm.rh && !mask_w[tac_pkg::MB_RH] |=> alert_out)
		else $error("remote high alarm did not raise alert");

	a_remote_ot_shutdown_output_pin: assert property (
		alm.rot && !mask_w[tac_pkg::MB_ROT] |=> shutdown_output_pin)
		else $error("remote overtemperature did not raise shutdown");

	a_fan_fail_out: assert property (
		fan_fail_output_pin == $past((alm.t2 && !mask_w[tac_pkg::MB_T2])
			|| (alm.t1 && !mask_w[tac_pkg::MB_T1])))
		else $error("fan fail output wrong");

	a_alert_masked: assert property (
		mask_w[tac_pkg::MB_LH] && mask_w[tac_pkg::MB_RH] |=> !alert_out)
		else $error("alert raised while both sources masked");

	a_mask_rsvd_ones: assert property (
		mask_w[7:6] == 2'b11)
		else $error("mask reserved bits not ones");

	a_ideality_follow: assert property (
		s_wr_ideal |=> ##1 ideality_code == $past(pwdata[5:0], 2)
			&& cfg_r[tac_pkg::IDX_IDEAL][7:6] == 2'b00)
		else $error("ideality setting not applied");

	a_lower_frac: assert property (
		cfg_r[tac_pkg::IDX_LHL][4:0] == 5'h00 && cfg_r[tac_pkg::IDX_RHL][4:0] == 5'h00
			&& cfg_r[tac_pkg::IDX_LOTL][4:0] == 5'h00 && cfg_r[tac_pkg::IDX_ROTL][4:0] == 5'h00)
		else $error("set-point lower byte low bits set");

	a_signed_compare: assert property (
		$signed(local_temp) > $signed(lim_lh) && $stable(lim_lh) |=> alm.lh)
		else $error("local high compare missed");

	a_pready_once: assert property (
		setup |=> pready ##1 !pready)
		else $error("pready not a single access cycle");

	a_duty_normal: assert property (
		!fan_failure_detected |=> pwm_duty_code == $past(normal_duty_code))
		else $error("normal duty not passed through");

	a_refuse_unmapped: assert property (
		setup && !mapped |=> pslverr && pready)
		else $error("unmapped access not refused");

	// a write-one clear that meets a live fan event must lose
	sequence s_clear_live_t1;
		wr_go && idx == tac_pkg::IDX_IRQ_STAT && alm.t1;
	endsequence

	a_stat_set_wins: assert property (
		s_clear_live_t1 |=> irq_stat_r[tac_pkg::MB_T1])
		else $error("status clear beat a new event");

	a_irq_level: assert property (
		irq == |(irq_stat_r & $past(irq_mask_r)))
		else $error("irq level does not follow unmasked status");

endmodule // tac_alarm_bank
`default_nettype wire

// >>> hw/tac_limit_cmp.sv
// signed temperature against set-point comparator with registered alarm
`timescale 1ns/100ps
`default_nettype none
module tac_limit_cmp #(
	parameter int W = 16
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic [W-1:0] temp,
	input wire logic [W-1:0] limit,
	output logic exceed_r
);

	wire logic above;

	// both operands carry the sign in the top bit
	assign above = $signed(temp) > $signed(limit);

	// alarm level follows the comparison one clock later
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			exceed_r <= 1'b0;
		end else begin
			exceed_r <= above;
		end
	end

endmodule // tac_limit_cmp
`default_nettype wire

// >>> hw/tac_pkg.sv
// shared constants, types and helpers for the thermal alarm configuration bank
package tac_pkg;

	// register word indices; byte address is four times the index
	localparam logic [5:0] IDX_FIRST = 6'h03;
	localparam logic [5:0] IDX_FDUTY = 6'h03;
	localparam logic [5:0] IDX_MASK = 6'h04;
	localparam logic [5:0] IDX_IDEAL = 6'h05;
	localparam logic [5:0] IDX_RHU = 6'h06;
	localparam logic [5:0] IDX_RHL = 6'h07;
	localparam logic [5:0] IDX_LOTU = 6'h08;
	localparam logic [5:0] IDX_LOTL = 6'h09;
	localparam logic [5:0] IDX_ROTU = 6'h0A;
	localparam logic [5:0] IDX_ROTL = 6'h0B;
	localparam logic [5:0] IDX_LHU = 6'h0C;
	localparam logic [5:0] IDX_LHL = 6'h0D;
	localparam logic [5:0] IDX_LAST = 6'h0D;
	localparam logic [5:0] IDX_IRQ_STAT = 6'h20;
	localparam logic [5:0] IDX_IRQ_MASK = 6'h21;
	localparam logic [5:0] IDX_LIVE = 6'h22;

	// power-up values held in nonvolatile storage
	localparam logic [7:0] RST_FDUTY = 8'hFF;
	localparam logic [7:0] RST_MASK = 8'hC0;
	localparam logic [7:0] RST_IDEAL = 8'h18;
	localparam logic [7:0] RST_RHU = 8'h55;
	localparam logic [7:0] RST_LOTU = 8'h55;
	localparam logic [7:0] RST_ROTU = 8'h6E;
	localparam logic [7:0] RST_LHU = 8'h46;
	localparam logic [7:0] RST_LOWER = 8'h00;
	localparam logic [5:0] RST_IRQ_MASK = 6'h00;

	// field layouts
	localparam logic [7:0] MASK_RSVD_ONES = 8'hC0;
	localparam logic [7:0] IDEAL_FIELD = 8'h3F;
	localparam logic [7:0] FRAC_FIELD = 8'hE0;
	localparam int MB_LH = 5;
	localparam int MB_LOT = 4;
	localparam int MB_RH = 3;
	localparam int MB_ROT = 2;
	localparam int MB_T2 = 1;
	localparam int MB_T1 = 0;

	// alarm sources, packed in the same order as the mask bits
	typedef struct packed {
		logic lh;
		logic lot;
		logic rh;
		logic rot;
		logic t2;
		logic t1;
	} tac_alarm_t;

	// the three alarm outputs travelling together
	typedef struct packed {
		logic alert;
		logic shut;
		logic ffail;
	} tac_out_t;

	// power-up value of a configuration word
	function automatic logic [7:0] tac_rst_val(input logic [5:0] idx);
		case (idx)
			IDX_FDUTY: tac_rst_val = RST_FDUTY;
			IDX_MASK: tac_rst_val = RST_MASK;
			IDX_IDEAL: tac_rst_val = RST_IDEAL;
			IDX_RHU: tac_rst_val = RST_RHU;
			IDX_LOTU: tac_rst_val = RST_LOTU;
			IDX_ROTU: tac_rst_val = RST_ROTU;
			IDX_LHU: tac_rst_val = RST_LHU;
			default: tac_rst_val = RST_LOWER;
		endcase
	endfunction

	// stored value of a write; reserved and unused bits forced
	function automatic logic [7:0] tac_wr_val(input logic [5:0] idx, input logic [7:0] d);
		case (idx)
			IDX_MASK: tac_wr_val = d | MASK_RSVD_ONES;
			IDX_IDEAL: tac_wr_val = d & IDEAL_FIELD;
			IDX_RHL, IDX_LOTL, IDX_ROTL, IDX_LHL: tac_wr_val = d & FRAC_FIELD;
			default: tac_wr_val = d;
		endcase
	endfunction

endpackage

// >>> verification/tac_alarm_bank_tb.sv
// self-checking testbench for the thermal alarm configuration bank
`timescale 1ns/100ps
`default_nettype none
module tb;
	typedef struct packed {
		logic w;
		logic [31:0] d;
		logic e;
	} tac_note_t;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e1, e2, ffd;
	logic alert, shut, ffail, irq;
	logic [7:0] paddr, nduty, pwm, d, nd, m;
	logic [31:0] pwdata, prdata;
	logic [15:0] lt, rt;
	logic [5:0] ideal;
	logic [2:0] ex;
	logic [15:0] tt [0:10];
	logic [7:0] rv [3:13];
	tac_note_t q [$];
	tac_note_t n;
	int n_mismatch, n_checks, seed, i;
	////////////////////////////////////////////////////////////////////////
	tac_alarm_bank dut_u (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .local_temp(lt), .remote_temp(rt),
		.first_fan_alarm_event(e1), .second_fan_alarm_event(e2),
		.fan_failure_detected(ffd), .normal_duty_code(nduty), .pwm_duty_code(pwm),
		.ideality_code(ideal), .alert_out(alert), .shutdown_output_pin(shut),
		.fan_fail_output_pin(ffail), .irq(irq)
	);
	////////////////////////////////////////////////////////////////////////
	// 8 ns clock
	initial begin
		pclk = 1'b0;
		forever #4 pclk = ~pclk;
	end
	task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic cyc(input int c);
		repeat (c) @(posedge pclk);
	endtask
	// one apb transfer; the note goes in before the request so the monitor finds it
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd,
			input logic [31:0] ed, input logic ee);
		q.push_back(tac_note_t'{w, ed, ee});
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		// only the watchdog ends a wait that never sees pready
		while (pready !== 1'b1) begin
			@(posedge pclk);
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] wd);
		xfer(1'b1, a, wd, 32'h0, 1'b0);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ed);
		xfer(1'b0, a, 32'h0, ed, 1'b0);
	endtask
	// lower set-point bytes keep only their three fraction bits
	function automatic logic [7:0] wm(input int idx, input logic [7:0] v);
		wm = (idx == 7 || idx == 9 || idx == 11 || idx == 13) ? (v & 8'hE0) : v;
	endfunction
	// expected {alert, shutdown, fan fail} against the limits set below
	function automatic logic [2:0] expo(input logic [15:0] l, r, input logic a, b,
			input logic [7:0] k);
		expo[2] = ($signed(l) > $signed(16'h1000) && !k[5]) ||
			($signed(r) > $signed(16'hF800) && !k[3]);
		expo[1] = ($signed(l) > $signed(16'h2000) && !k[4]) ||
			($signed(r) > $signed(16'h2020) && !k[2]);
		expo[0] = (a && !k[0]) || (b && !k[1]);
	endfunction
	task automatic results;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////////
	// monitor: the oldest note is matched against each completed transfer
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1) begin
			if (q.size() == 0) begin
				cmp("note queue", 32'h1, 32'h0);
			end else begin
				n = q.pop_front();
				cmp("pslverr", 32'(n.e), 32'(pslverr));
				if (!n.w) begin
					cmp("prdata", n.d, prdata);
				end
			end
		end
	end
	// watchdog, far beyond the few hundred cycles the run needs
	initial begin
		#200000;
		n_mismatch++;
		results;
	end
	////////////////////////////////////////////////////////////////////////
	initial begin
		seed = 32'h0D27;
		n_mismatch = 0;
		n_checks = 0;
		presetn = 1'b0;
		{psel, penable, pwrite, e1, e2, ffd} = 6'h00;
		paddr = 8'h00;
		pwdata = 32'h0;
		nduty = 8'h00;
		lt = 16'h0800;
		rt = 16'hF000;
		rv = '{8'hFF, 8'hC0, 8'h18, 8'h55, 8'h00, 8'h55, 8'h00, 8'h6E, 8'h00, 8'h46, 8'h00};
		tt = '{16'h0800, 16'h1000, 16'h1001, 16'h1800, 16'h2000, 16'h2020, 16'h2021,
			16'h2800, 16'hF000, 16'hF800, 16'hF801};
		cyc(12);
		presetn <= 1'b1;
		cyc(2);
		cmp("ideality", 32'h18, 32'(ideal));
		for (i = 3; i <= 13; i++) begin
			rd(8'(i * 4), {24'h0, rv[i]});
		end
		// random contents, reserved bits written as software must
		for (i = 3; i <= 13; i++) begin
			d = 8'($random(seed));
			if (i == 4) d = d | 8'hC0;
			if (i == 5) d = d & 8'h3F;
			wr(8'(i * 4), {24'h0, d});
			rd(8'(i * 4), {24'h0, wm(i, d)});
			if (i == 5) begin
				cyc(2);
				cmp("ideality", 32'(d[5:0]), 32'(ideal));
			end
		end
		// unmapped and unaligned places are refused
		xfer(1'b0, 8'h40, 32'h0, 32'h0, 1'b1);
		xfer(1'b0, 8'h0D, 32'h0, 32'h0, 1'b1);
		xfer(1'b1, 8'h38, 32'hA5, 32'h0, 1'b1);
		xfer(1'b0, 8'h38, 32'h0, 32'h0, 1'b1);
		// failure duty replaces the normal code only while a failure is flagged
		for (i = 0; i < 4; i++) begin
			d = 8'($random(seed));
			nd = 8'($random(seed));
			wr(8'h0C, {24'h0, d});
			@(posedge pclk);
			ffd <= 1'b1;
			nduty <= nd;
			cyc(2);
			cmp("pwm duty", 32'(d), 32'(pwm));
			ffd <= 1'b0;
			cyc(2);
			cmp("pwm duty", 32'(nd), 32'(pwm));
		end
		// limits: local high 16, local over 32, remote high -8, remote over 32.125
		wr(8'h30, 32'h10);
		wr(8'h34, 32'h00);
		wr(8'h20, 32'h20);
		wr(8'h24, 32'h00);
		wr(8'h18, 32'hF8);
		wr(8'h1C, 32'h00);
		wr(8'h28, 32'h20);
		wr(8'h2C, 32'h20);
		for (i = 0; i < 30; i++) begin
			m = 8'($random(seed)) | 8'hC0;
			wr(8'h10, {24'h0, m});
			rd(8'h10, {24'h0, m});
			@(posedge pclk);
			lt <= tt[{$random(seed)} % 11];
			rt <= tt[{$random(seed)} % 11];
			{e2, e1} <= 2'($random(seed));
			cyc(3);
			ex = expo(lt, rt, e1, e2, m);
			cmp("alert", 32'(ex[2]), 32'(alert));
			cmp("shutdown", 32'(ex[1]), 32'(shut));
			cmp("fan fail", 32'(ex[0]), 32'(ffail));
		end
		// interrupt: sticky status, mask, level output, write one to clear
		wr(8'h10, 32'hC0);
		@(posedge pclk);
		lt <= 16'h0800;
		rt <= 16'hF000;
		{e2, e1} <= 2'b00;
		cyc(4);
		wr(8'h80, 32'h3F);
		rd(8'h80, 32'h0);
		@(posedge pclk);
		e1 <= 1'b1;
		cyc(3);
		rd(8'h80, 32'h1);
		rd(8'h88, 32'h101);
		// a clear that meets a still active event loses
		wr(8'h80, 32'h1);
		rd(8'h80, 32'h1);
		cmp("irq", 32'h0, 32'(irq));
		wr(8'h84, 32'h1);
		cyc(3);
		cmp("irq", 32'h1, 32'(irq));
		e1 <= 1'b0;
		cyc(3);
		rd(8'h80, 32'h1);
		cmp("irq", 32'h1, 32'(irq));
		wr(8'h80, 32'h1);
		cyc(3);
		cmp("irq", 32'h0, 32'(irq));
		rd(8'h80, 32'h0);
		cyc(2);
		// mid-run reset brings back the stored image
		presetn <= 1'b0;
		cyc(3);
		presetn <= 1'b1;
		cyc(2);
		cmp("irq", 32'h0, 32'(irq));
		rd(8'h10, 32'hC0);
		rd(8'h14, 32'h18);
		rd(8'h30, 32'h46);
		rd(8'h80, 32'h0);
		cyc(2);
		results;
	end
endmodule // tb
`default_nettype wire
